// [design/standby_peripheral_gating.sv]
// Standby gating: decides which peripherals run in light and deep standby
// Assumes event pins are asynchronous and the requests/enables come from CLK logic
`timescale 1ns/1ps
`default_nettype none
module standby_peripheral_gating #(
  parameter int IRQ_NUM = 4,
  parameter int INTERVAL_LEN = standby_pkg::INTERVAL_LEN_DEFAULT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Standby entry requests from the CPU
  input wire logic ENTER_LIGHT,
  input wire logic ENTER_DEEP,
  // Configuration
  input wire standby_pkg::src_sel_t SRC_SEL,
  input wire logic [3:0] IRQ_ZERO_EDGE_MODE,
  // Peripheral interrupt requests and their enables
  input wire logic [IRQ_NUM-1:0] PERIPH_IRQ,
  input wire logic [IRQ_NUM-1:0] PERIPH_IRQ_EN,
  // External pins
  input wire logic EVENT_COUNT_PIN,
  input wire logic EXT_IRQ_ZERO,
  input wire logic EXT_IRQ_ONE,
  input wire logic EXT_IRQ_TWO,
  input wire logic EXT_IRQ_FOUR,
  // Status and gating outputs, with the clear inputs for the flags
  output var standby_pkg::mode_t MODE,
  output var standby_pkg::gate_t GATE,
  output logic [3:0] EXT_IRQ_FLAGS,
  input wire logic [3:0] EXT_IRQ_CLEAR,
  output logic INTERVAL_TIMER_REQUEST_FLAG,
  input wire logic INTERVAL_FLAG_CLEAR,
  output logic EVENT_COUNT_TICK
);
  import standby_pkg::*;

  // Pin synchronisers: two flops, then a third stage for edge detection
  logic [4:0] pins_in;
  logic [4:0] sync1_reg, sync2_reg, sync3_reg;
  assign pins_in = {EVENT_COUNT_PIN, EXT_IRQ_FOUR, EXT_IRQ_TWO, EXT_IRQ_ONE, EXT_IRQ_ZERO};
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  logic [4:0] rise;
  assign rise = sync2_reg & ~sync3_reg;

  // Standby test shared by the gates, the filter and the checks
  function automatic logic is_standby(input mode_t m);
    return m != MODE_RUN;
  endfunction

  // Mode state machine
  mode_t mode_reg, mode_next;
  logic wake;
  // Pending pin flags count as enabled requests, so an old edge wakes at once
  assign wake = |(PERIPH_IRQ & PERIPH_IRQ_EN) | (|(EXT_IRQ_FLAGS));
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_RUN: begin
        if (ENTER_DEEP) begin
          mode_next = MODE_DEEP;
        end else if (ENTER_LIGHT) begin
          mode_next = MODE_LIGHT;
        end
      end
      MODE_LIGHT, MODE_DEEP: begin
        if (wake) begin
          mode_next = MODE_RUN;
        end
      end
      default: mode_next = MODE_RUN;
    endcase
  end

  // Gate computation; reset leaves standby via the async reset
  gate_t gate_next;
  logic in_sb, in_deep;
  assign in_sb = is_standby(mode_next);
  assign in_deep = (mode_next == MODE_DEEP);
  always_comb begin
    gate_next.cpu = !in_sb;
    gate_next.main_osc = !in_deep;
    gate_next.tec = in_deep ? SRC_SEL.tec_pin_src : 1'b1;
    gate_next.gen_timer = !in_deep;
    gate_next.clk_timer = in_deep ? SRC_SEL.clk_timer_sub_src : 1'b1;
    gate_next.interval = !in_deep;
  end

  // Interrupt zero is only live in standby when its filter is bypassed
  logic zero_live;
  assign zero_live = !is_standby(mode_reg) || IRQ_ZERO_EDGE_MODE[FILTER_BYPASS_POS];
  logic [3:0] flags_next;
  logic [3:0] flag_set;
  assign flag_set = {rise[3], rise[2], rise[1], rise[0] & zero_live};
  // Set wins over clear so a coinciding edge is not lost
  always_comb begin
    flags_next = (EXT_IRQ_FLAGS & ~EXT_IRQ_CLEAR) | flag_set;
  end

  // Interval timer: counts only when its gate is open
  logic [15:0] ivl_cnt_reg, ivl_cnt_next;
  logic ivl_flag_next;
  logic ivl_hit;
  assign ivl_hit = GATE.interval && (ivl_cnt_reg == 16'(INTERVAL_LEN - 1));
  always_comb begin
    ivl_cnt_next = ivl_cnt_reg;
    if (GATE.interval) begin
      ivl_cnt_next = ivl_hit ? 16'h0000 : ivl_cnt_reg + 16'h0001;
    end
    ivl_flag_next = ivl_hit | (INTERVAL_TIMER_REQUEST_FLAG & ~INTERVAL_FLAG_CLEAR);
  end

  // Event tick for the timer/event counter, gated by its enable
  logic tick_next;
  assign tick_next = GATE.tec && SRC_SEL.tec_pin_src && rise[4];

  // State registers; outputs come straight from flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_reg <= MODE_RUN;
      GATE <= '1;
      EXT_IRQ_FLAGS <= 4'h0;
      ivl_cnt_reg <= 16'h0000;
      INTERVAL_TIMER_REQUEST_FLAG <= 1'b0;
      EVENT_COUNT_TICK <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      GATE <= gate_next;
      EXT_IRQ_FLAGS <= flags_next;
      ivl_cnt_reg <= ivl_cnt_next;
      INTERVAL_TIMER_REQUEST_FLAG <= ivl_flag_next;
      EVENT_COUNT_TICK <= tick_next;
    end
  end
  assign MODE = mode_reg;

  // Assertions: gates follow the mode register, so they are checked against it
  a_deep_osc_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_DEEP) |-> !GATE.main_osc && !GATE.gen_timer)
    else $error("oscillator or timer running in deep standby");
  a_light_cpu_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_LIGHT) |-> !GATE.cpu && GATE.main_osc)
    else $error("light standby gating wrong");
  a_deep_tec_src: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_DEEP) |-> GATE.tec == $past(SRC_SEL.tec_pin_src))
    else $error("event counter gate wrong in deep standby");
  a_light_tec_on: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_LIGHT) |-> GATE.tec && GATE.clk_timer)
    else $error("counter or clock timer stopped in light standby");
  a_deep_clk_src: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_DEEP) |-> GATE.clk_timer == $past(SRC_SEL.clk_timer_sub_src))
    else $error("clock timer gate wrong in deep standby");
  a_deep_entry: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_RUN && ENTER_DEEP) |=> mode_reg == MODE_DEEP)
    else $error("deep standby request not taken");
  a_light_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_reg == MODE_LIGHT && !wake) |=> mode_reg == MODE_LIGHT)
    else $error("light standby left without a release");
  a_run_gates_open: assert property (@(posedge CLK) disable iff (!RESET_N)
    !is_standby(mode_reg) |-> &GATE)
    else $error("a gate closed in run mode");
  a_tick_gated: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!GATE.tec || !SRC_SEL.tec_pin_src) |=> !EVENT_COUNT_TICK)
    else $error("event tick while the counter is held");

  // Flag checks: edges on one, two and four must land; interrupt zero must land when bypassed and stay clear in standby with its filter selected
  a_irq_one_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    rise[1] |=> EXT_IRQ_FLAGS[1])
    else $error("interrupt one edge lost");
  a_irq_two_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    rise[2] |=> EXT_IRQ_FLAGS[2])
    else $error("interrupt two edge lost");
  a_irq_four_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    rise[3] |=> EXT_IRQ_FLAGS[3])
    else $error("interrupt four edge lost");
  a_irq_zero_filt: assert property (@(posedge CLK) disable iff (!RESET_N)
    (is_standby(mode_reg) && !IRQ_ZERO_EDGE_MODE[FILTER_BYPASS_POS] && !EXT_IRQ_FLAGS[0])
    |=> !EXT_IRQ_FLAGS[0])
    else $error("interrupt zero active with filter selected");
  a_zero_bypass_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    (rise[0] && IRQ_ZERO_EDGE_MODE[FILTER_BYPASS_POS]) |=> EXT_IRQ_FLAGS[0])
    else $error("interrupt zero edge lost with filter bypassed");
  a_wake_release: assert property (@(posedge CLK) disable iff (!RESET_N)
    (is_standby(mode_reg) && |(PERIPH_IRQ & PERIPH_IRQ_EN)) |=> mode_reg == MODE_RUN)
    else $error("enabled request did not release standby");
  a_flag_wake: assert property (@(posedge CLK) disable iff (!RESET_N)
    (is_standby(mode_reg) && |EXT_IRQ_FLAGS) |=> mode_reg == MODE_RUN)
    else $error("pending pin flag did not release standby");

  // Interval timer checks
  a_ivl_deep_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!GATE.interval) |=> $stable(ivl_cnt_reg))
    else $error("interval timer ran in deep standby");
  a_ivl_flag_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    ivl_hit |=> INTERVAL_TIMER_REQUEST_FLAG)
    else $error("interval flag not set at the interval");
  a_ivl_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
    (INTERVAL_TIMER_REQUEST_FLAG && !INTERVAL_FLAG_CLEAR)
    |=> INTERVAL_TIMER_REQUEST_FLAG)
    else $error("interval flag dropped without a clear");
endmodule
`default_nettype wire

// [design/standby_pkg.sv]
// Package for the standby peripheral gating block
// Assumes a single 250 MHz system clock domain
package standby_pkg;
  // Clock period in ns
  localparam int CLK_PERIOD_NS = 4;
  // Standby mode encoding
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_LIGHT = 2'b01,
    MODE_DEEP = 2'b10
  } mode_t;
  // Edge mode register bit position of the filter bypass bit
  localparam int FILTER_BYPASS_POS = 2;
  localparam logic [3:0] EDGE_MODE_RESET = 4'h0;
  localparam int INTERVAL_LEN_DEFAULT = 16;
  // Count source selections of the peripherals
  typedef struct packed {
    logic tec_pin_src;
    logic clk_timer_sub_src;
  } src_sel_t;
  // Per-peripheral run enables
  typedef struct packed {
    logic cpu;
    logic main_osc;
    logic tec;
    logic gen_timer;
    logic clk_timer;
    logic interval;
  } gate_t;
endpackage

// [tb/standby_peripheral_gating_bench.sv]
// Self-checking bench for the standby gating block
// Assumes the package is compiled first; inputs are driven just after rising edges
`timescale 1ns/1ps
`default_nettype none
module standby_peripheral_gating_bench;
  import standby_pkg::*;
  logic CLK = 0, RESET_N = 0, ENTER_LIGHT = 0, ENTER_DEEP = 0, EVENT_COUNT_PIN = 0;
  logic INTERVAL_FLAG_CLEAR = 0;
  src_sel_t SRC_SEL = '0;
  logic [3:0] IRQ_ZERO_EDGE_MODE = 4'h0, PERIPH_IRQ = 4'h0, PERIPH_IRQ_EN = 4'h0;
  logic [3:0] pins = 4'h0, EXT_IRQ_CLEAR = 4'h0, EXT_IRQ_FLAGS;
  mode_t MODE;
  gate_t GATE;
  logic INTERVAL_TIMER_REQUEST_FLAG, EVENT_COUNT_TICK;
  logic [7:0] n_ticks = 8'h00, tick_base = 8'h00, n_ivl = 8'h00, ivl_base = 8'h00;
  int n_fail = 0, n_tests = 0;
  // Short interval keeps the flag checks within a few cycles
  standby_peripheral_gating #(.INTERVAL_LEN(4)) i_dut (.CLK(CLK), .RESET_N(RESET_N),
    .ENTER_LIGHT(ENTER_LIGHT), .ENTER_DEEP(ENTER_DEEP), .SRC_SEL(SRC_SEL),
    .IRQ_ZERO_EDGE_MODE(IRQ_ZERO_EDGE_MODE), .PERIPH_IRQ(PERIPH_IRQ),
    .PERIPH_IRQ_EN(PERIPH_IRQ_EN), .EVENT_COUNT_PIN(EVENT_COUNT_PIN),
    .EXT_IRQ_ZERO(pins[0]), .EXT_IRQ_ONE(pins[1]), .EXT_IRQ_TWO(pins[2]),
    .EXT_IRQ_FOUR(pins[3]), .MODE(MODE), .GATE(GATE), .EXT_IRQ_FLAGS(EXT_IRQ_FLAGS),
    .EXT_IRQ_CLEAR(EXT_IRQ_CLEAR), .INTERVAL_TIMER_REQUEST_FLAG(INTERVAL_TIMER_REQUEST_FLAG),
    .INTERVAL_FLAG_CLEAR(INTERVAL_FLAG_CLEAR), .EVENT_COUNT_TICK(EVENT_COUNT_TICK));
  // 4 ns clock
  initial forever #2 CLK = ~CLK;
  // Tick counter; a pulse is one cycle wide so each edge counts once
  always @(posedge CLK) if (EVENT_COUNT_TICK === 1'b1) n_ticks <= n_ticks + 8'h01;
  // Interval pulse counter; only meaningful while the flag clear is held
  always @(posedge CLK) if (INTERVAL_TIMER_REQUEST_FLAG === 1'b1) n_ivl <= n_ivl + 8'h01;
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // One-cycle entry request, mode visible after the taking edge
  task automatic enter(input logic deep);
    ENTER_DEEP <= deep;
    ENTER_LIGHT <= !deep;
    cyc(1);
    ENTER_DEEP <= 1'b0;
    ENTER_LIGHT <= 1'b0;
    #1 chk(8'(MODE), deep ? 8'(MODE_DEEP) : 8'(MODE_LIGHT));
  endtask
  // Bounded wait for release back to run mode
  task automatic wait_run();
    int k;
    k = 0;
    while (MODE !== MODE_RUN && k < 20) begin
      cyc(1);
      k++;
    end
    #1;
    if (k == 20) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 8'(MODE), 8'(MODE_RUN));
      print_verdict();
    end else chk(8'(GATE), 8'h3f);
  endtask
  initial begin
    cyc(20);
    RESET_N <= 1'b1;
    #1 chk(8'(GATE), 8'h3f);
    // Every source selection in deep standby
    for (int s = 0; s < 4; s++) begin
      SRC_SEL <= src_sel_t'(s[1:0]);
      cyc(1);
      enter(1'b1);
      chk(8'(GATE), 8'({s[1], 1'b0, s[0], 1'b0}));
      INTERVAL_FLAG_CLEAR <= 1'b1;
      tick_base = n_ticks;
      cyc(1);
      INTERVAL_FLAG_CLEAR <= 1'b0;
      repeat (2) begin
        EVENT_COUNT_PIN <= 1'b1;
        cyc(4);
        EVENT_COUNT_PIN <= 1'b0;
        cyc(4);
      end
      #1 chk(n_ticks - tick_base, 8'(2 * s[1]));
      chk(8'(INTERVAL_TIMER_REQUEST_FLAG), 8'h00);
      // A request without its enable must not release
      PERIPH_IRQ <= 4'h1 << s;
      cyc(4);
      #1 chk(8'(MODE), 8'(MODE_DEEP));
      PERIPH_IRQ_EN <= 4'h1 << s;
      wait_run();
      PERIPH_IRQ <= 4'h0;
      PERIPH_IRQ_EN <= 4'h0;
      cyc(1);
    end
    // Light standby gates, interval flag and refused deep entry
    enter(1'b0);
    chk(8'(GATE), 8'h1f);
    // Holding the clear turns the sticky flag into one pulse per interval of four
    INTERVAL_FLAG_CLEAR <= 1'b1;
    cyc(1);
    #1 ivl_base = n_ivl;
    cyc(12);
    #1 chk(n_ivl - ivl_base, 8'h03);
    INTERVAL_FLAG_CLEAR <= 1'b0;
    cyc(4);
    #1 chk(8'(INTERVAL_TIMER_REQUEST_FLAG), 8'h01);
    ENTER_DEEP <= 1'b1;
    cyc(2);
    ENTER_DEEP <= 1'b0;
    #1 chk(8'(MODE), 8'(MODE_LIGHT));
    // Interrupts one and two wake light, four wakes deep
    for (int i = 1; i < 4; i++) begin
      if (i != 1) enter(i == 3);
      pins[i] <= 1'b1;
      wait_run();
      chk(8'(EXT_IRQ_FLAGS), 8'(4'h1 << i));
      pins <= 4'h0;
      EXT_IRQ_CLEAR <= 4'hf;
      cyc(1);
      EXT_IRQ_CLEAR <= 4'h0;
      cyc(1);
    end
    // Interrupt zero ignored with the filter, seen with it bypassed
    enter(1'b1);
    pins[0] <= 1'b1;
    cyc(8);
    #1 chk(8'(EXT_IRQ_FLAGS), 8'h00);
    chk(8'(MODE), 8'(MODE_DEEP));
    pins[0] <= 1'b0;
    IRQ_ZERO_EDGE_MODE <= 4'h4;
    cyc(4);
    pins[0] <= 1'b1;
    wait_run();
    chk(8'(EXT_IRQ_FLAGS), 8'h01);
    // Reset from deep standby; pins go low first so no false edge follows it
    pins <= 4'h0;
    EXT_IRQ_CLEAR <= 4'hf;
    cyc(1);
    EXT_IRQ_CLEAR <= 4'h0;
    cyc(1);
    enter(1'b1);
    RESET_N <= 1'b0;
    #1 chk(8'(MODE), 8'(MODE_RUN));
    chk(8'(GATE), 8'h3f);
    cyc(2);
    RESET_N <= 1'b1;
    cyc(1);
    enter(1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
